// *** dv/bsp_spi_peer.sv ***
// Behavioural SPI slave facing the port; send and receive bytes kept in queues.
// Assumes the bench fills tx_q and sets the mode inputs before lowering cs_n.
`timescale 1ns/1ps
module bsp_spi_peer (
	// Select and mode
	input  wire logic cs_n,
	input  wire logic clock_polarity,
	input  wire logic clock_phase,
	input  wire logic lsb,
	// Serial lines
	input  wire logic sclk,
	input  wire logic mosi,
	output logic      miso
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] sh_o;
	logic [7:0] sh_i;
	int         n_o;
	int         n_i;
	bit         first;
	initial miso = 1'b1;
	task automatic put();
		miso = lsb ? sh_o[0] : sh_o[7];
	endtask : put
	always @(negedge cs_n) begin
		sh_o = tx_q.pop_front();
		n_o = 0;
		n_i = 0;
		first = clock_phase;
		if (!clock_phase) put();
		else miso = ~miso;
	end
	// Released line flips so a stale bit cannot pass for data
	always @(posedge cs_n) miso = ~miso;
	always @(sclk) if (!cs_n) begin
		if ((sclk != clock_polarity) ^ clock_phase) begin
			sh_i = lsb ? {mosi, sh_i[7:1]} : {sh_i[6:0], mosi};
			n_i++;
			if (n_i == 8) begin
				rx_q.push_back(sh_i);
				n_i = 0;
			end
		end else if (first) begin
			// Phase one: first bit goes out on the first leading edge
			first = 1'b0;
			put();
		end else begin
			sh_o = lsb ? sh_o >> 1 : sh_o << 1;
			n_o++;
			if (n_o == 8 && tx_q.size() > 0) begin
				n_o = 0;
				sh_o = tx_q.pop_front();
			end
			put();
		end
	end
endmodule : bsp_spi_peer

// *** dv/buffered_spi_port_tb_top.sv ***
// Self-checking bench: AXI4-Lite master, SPI peer, queued read checks.
// Assumes the port runs as master toward the peer; its select pin stays high.
`timescale 1ns/1ps
module buffered_spi_port_tb_top;
	import bsp_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, irq, ss_n, cs_n;
	logic        sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, miso_p, clock_polarity, clock_phase, lsb;
	wire         sck  = sck_oe ? sck_o : 1'b1;
	wire         mosi = mo_oe ? mo_o : 1'b1;
	wire         miso = mi_oe ? mi_o : miso_p;
	logic [33:0] exp_q[$];
	int          err_total, total_checks;

	bsp_port bsp_port_i (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .irq,
		.slave_select_pin_in(ss_n),
		.serial_clock_pin_in(sck),
		.serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe(sck_oe),
		.master_out_pin_in(mosi),
		.master_out_pin_out(mo_o),
		.master_out_pin_oe(mo_oe),
		.master_in_pin_in(miso),
		.master_in_pin_out(mi_o),
		.master_in_pin_oe(mi_oe)
	);
	bsp_spi_peer bsp_spi_peer_i (
		.cs_n, .clock_polarity, .clock_phase, .lsb, .sclk(sck), .mosi, .miso(miso_p)
	);

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge aclk); while ((awready & wready) !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready  <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		exp_q.push_back({r, 24'h0, d});
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready  <= 1'b0;
	endtask : rd
	// Read results checked where they appear, against the oldest note
	always @(posedge aclk) if (rvalid === 1'b1 && rready === 1'b1) begin
		chk({rresp, rdata}, exp_q.pop_front());
	end

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] sent[8];
		logic [7:0] back[8];
		logic [2:0] md;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{aresetn, clock_polarity, clock_phase, lsb} = '0;
		{ss_n, cs_n} = 2'b11;
		wstrb = 4'hf;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'h77050ddf));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(BSP_ADDR_CTRL, 8'h00, BSP_RESP_OK);
		rd(BSP_ADDR_STAT, 8'h00, BSP_RESP_OK);
		rd(8'h2c, 8'h00, BSP_RESP_ERR);
		wr(BSP_ADDR_IE, 8'h03);
		rd(BSP_ADDR_IE, 8'h03, BSP_RESP_OK);
		// Every mode and bit order, extra count 0 up to 7
		for (int m = 0; m < 8; m++) begin
			md = 3'(m);
			{lsb, clock_phase, clock_polarity} = md;
			wr(BSP_ADDR_CTRL, {2'b11, lsb, 1'b1, clock_polarity, clock_phase, 2'b01});
			wr(BSP_ADDR_STAT, {5'h00, md});
			for (int i = 0; i <= m; i++) begin
				sent[i] = 8'($urandom);
				back[i] = 8'($urandom);
				bsp_spi_peer_i.tx_q.push_back(back[i]);
			end
			cs_n <= 1'b0;
			for (int i = 0; i <= m; i++) wr(BSP_ADDR_BUF0 + 8'(4 * i), sent[i]);
			wr(BSP_ADDR_BUF0, 8'($urandom));
			for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge aclk);
			chk(34'(irq), 34'h1);
			chk(34'(sck), 34'(clock_polarity));
			chk(34'(bsp_spi_peer_i.rx_q.size()), 34'(m + 1));
			for (int i = 0; i <= m; i++) begin
				chk(34'(bsp_spi_peer_i.rx_q.pop_front()), 34'(sent[i]));
				rd(BSP_ADDR_BUF0 + 8'(4 * i), back[i], BSP_RESP_OK);
			end
			rd(BSP_ADDR_STAT, {3'b110, 2'b00, md}, BSP_RESP_OK);
			wr(BSP_ADDR_STAT, {5'h00, md});
			rd(BSP_ADDR_STAT, {5'h00, md}, BSP_RESP_OK);
			chk(34'(irq), 34'h0);
			cs_n <= 1'b1;
		end
		// Fastest divider; returned data too late for the synchroniser, outgoing only
		{lsb, clock_phase, clock_polarity} = 3'b000;
		wr(BSP_ADDR_CTRL, 8'hd0);
		wr(BSP_ADDR_STAT, 8'h00);
		bsp_spi_peer_i.tx_q.push_back(8'h00);
		cs_n <= 1'b0;
		wr(BSP_ADDR_BUF0, 8'h3c);
		for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge aclk);
		chk(34'(irq), 34'h1);
		chk(34'(bsp_spi_peer_i.rx_q.pop_front()), 34'h3c);
		cs_n <= 1'b1;
		wr(BSP_ADDR_STAT, 8'h00);
		wr(BSP_ADDR_CTRL, 8'h00);
		repeat (2) @(posedge aclk);
		chk(34'({sck_oe, mo_oe, mi_oe}), 34'h0);
		tally_and_finish();
	end
endmodule : buffered_spi_port_tb_top

// *** logic/bsp_pkg.sv ***
// Constants, types and reset state of the buffered SPI port.
// Assumes a single 20 MHz system clock and an AXI4-Lite master outside.
package bsp_pkg;
	// Register byte addresses
	localparam logic [7:0] BSP_ADDR_CTRL = 8'h00;
	localparam logic [7:0] BSP_ADDR_STAT = 8'h04;
	localparam logic [7:0] BSP_ADDR_BUF0 = 8'h08;
	localparam logic [7:0] BSP_ADDR_IE   = 8'h28;
	localparam logic [3:0] BSP_IDX_LAST  = 4'ha;
	// Control register fields
	localparam int BSP_C_SIG  = 7;
	localparam int BSP_C_EN   = 6;
	localparam int BSP_C_ORD  = 5;
	localparam int BSP_C_MASTER_SELECT = 4;
	localparam int BSP_C_CLOCK_POLARITY = 3;
	localparam int BSP_C_CLOCK_PHASE = 2;
	// Status register fields
	localparam int BSP_S_DONE = 7;
	localparam int BSP_S_WRITE_COLLISION_FLAG = 6;
	localparam int BSP_S_CLOCK_DIVIDER_TOP_BIT = 5;
	// Interrupt enable / engine state register fields
	localparam int BSP_I_PIE  = 0;
	localparam int BSP_I_GIE  = 1;
	localparam int BSP_I_BUSY = 4;
	localparam int BSP_I_MAST = 5;
	// Clock edges per byte, counted from zero
	localparam logic [3:0] BSP_EDGE_LAST = 4'hf;
	localparam logic [1:0] BSP_RESP_OK   = 2'b00;
	localparam logic [1:0] BSP_RESP_ERR  = 2'b10;

	typedef enum logic [0:0] {
		BSP_ST_IDLE = 1'b0,
		BSP_ST_XFER = 1'b1
	} bsp_st_e;

	typedef struct packed {
		logic [7:0]      ctrl;
		logic            done;
		logic            write_collision_flag;
		logic            clock_divider_top_bit;
		logic [2:0]      xcnt;
		logic            pie;
		logic            gie;
		logic [7:0][7:0] buff;
		bsp_st_e         st;
		logic [2:0]      idx;
		logic [3:0]      edg;
		logic [7:0]      sh;
		logic [9:0]      div;
		logic            sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
		logic            irq;
		logic            ss_s1, ss_s2, ck_s1, ck_s2, ck_s3;
		logic            mo_s1, mo_s2, mi_s1, mi_s2;
		logic            axw, bvalid, arready, rvalid;
		logic [1:0]      bresp, rresp;
		logic [31:0]     rdata;
	} bsp_state_s;

	localparam bsp_state_s BSP_STATE_RST = '0;

	// Half period of the master clock in system clocks
	function automatic logic [9:0] bsp_half(input logic [2:0] clock_divider_select);
		unique case (clock_divider_select)
			3'h0: bsp_half = 10'h002;
			3'h1: bsp_half = 10'h008;
			3'h2: bsp_half = 10'h020;
			3'h3: bsp_half = 10'h040;
			3'h4: bsp_half = 10'h080;
			3'h5: bsp_half = 10'h100;
			default: bsp_half = 10'h200;
		endcase
	endfunction : bsp_half
endpackage : bsp_pkg

// *** logic/bsp_port.sv ***
// Buffered SPI port: eight-byte buffer, master or slave, AXI4-Lite registers.
// Assumes pins arrive asynchronously and pad logic resolves the enables.
// Behaviour
// [R1] Transfer moves one plus extra count bytes
// [R2] Byte zero first, then ascending buffer index
// [R3] Select ignore set: master bit alone decides
// [R4] Select ignore clear: select pin decides mode
// [R5] Disabled port releases all four pins
// [R6] Bit order one sends LSB first
// [R7] Polarity sets the idle clock level
// [R8] Phase one: drive leading, sample trailing
// [R9] Phase zero: first bit early, sample leading
// [R10] Three-bit divider picks master clock rate
// [R11] Software keeps divider select nonzero always; the bench writes select zero in its fastest-divider test
// [R12] Transfer end sets done flag, gated interrupt
// [R13] Select pin low as master sets done
// [R14] Buffer write during transfer sets collision
// [R15] Collision cleared only by writing zero
// [R16] Software loads buffer bytes in order
// [R17] Writing last byte starts the transfer
// [R18] Collision on writes up to extra count
// [R19] Full duplex exchange of shift registers
// [R20] Unselected slave holds its output high; a phase zero start while unselected puts the first bit out for one cycle
// [R21] Received byte replaces sent byte; code 111 undefined
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module bsp_port
	import bsp_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Serial pins
	input  wire logic        slave_select_pin_in,
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe,
	input  wire logic        master_out_pin_in,
	output logic             master_out_pin_out,
	output logic             master_out_pin_oe,
	input  wire logic        master_in_pin_in,
	output logic             master_in_pin_out,
	output logic             master_in_pin_oe,
	// Interrupt request
	output logic             irq
);
	bsp_state_s q, n;

	logic       en, sig, master_select, clock_polarity, clock_phase, ord, busy, master, selected, mfault;
	logic       tick, lead, sample, din, ev_done, ev_write_collision_flag, wr, rd, wmap, rmap;
	logic [3:0] widx, ridx;
	logic [2:0] bidx;
	logic [7:0] rbyte;

	assign en       = q.ctrl[BSP_C_EN];
	assign sig      = q.ctrl[BSP_C_SIG];
	assign master_select     = q.ctrl[BSP_C_MASTER_SELECT];
	assign clock_polarity     = q.ctrl[BSP_C_CLOCK_POLARITY];
	assign clock_phase     = q.ctrl[BSP_C_CLOCK_PHASE];
	assign ord      = q.ctrl[BSP_C_ORD];
	assign busy     = (q.st == BSP_ST_XFER);
	assign master   = master_select && (sig || q.ss_s2);                    // [R3] [R4]
	assign selected = sig || !q.ss_s2;
	assign mfault   = en && !sig && master_select && !q.ss_s2;              // [R13]
	assign wr       = q.axw && awvalid && wvalid;
	assign rd       = q.arready && arvalid;
	assign widx     = awaddr[5:2];
	assign ridx     = araddr[5:2];
	assign wmap     = (awaddr[7:6] == 2'b00) && (widx <= BSP_IDX_LAST);
	assign rmap     = (araddr[7:6] == 2'b00) && (ridx <= BSP_IDX_LAST);
	assign bidx     = 3'(widx - 4'h2);

	always_comb begin
		unique case (ridx)
			BSP_ADDR_CTRL[5:2]: rbyte = q.ctrl;
			BSP_ADDR_STAT[5:2]: rbyte = {q.done, q.write_collision_flag, q.clock_divider_top_bit, 2'b00, q.xcnt};
			BSP_ADDR_IE[5:2]:   rbyte = {2'b00, master, busy, 2'b00, q.gie, q.pie};
			default:            rbyte = (ridx >= 4'h2 && ridx <= 4'h9) ?
			                            q.buff[3'(ridx - 4'h2)] : 8'h00;
		endcase
	end

	always_comb begin
		n       = q;
		ev_done = 1'b0;
		ev_write_collision_flag = 1'b0;
		tick    = 1'b0;
		din     = 1'b0;
		lead    = 1'b0;
		sample  = 1'b0;

		// Two-stage synchronisers, three stages for the clock; the first stage feeds only the second
		n.ss_s1 = slave_select_pin_in;
		n.ss_s2 = q.ss_s1;
		n.ck_s1 = serial_clock_pin_in;
		n.ck_s2 = q.ck_s1;
		n.ck_s3 = q.ck_s2;
		n.mo_s1 = master_out_pin_in;
		n.mo_s2 = q.mo_s1;
		n.mi_s1 = master_in_pin_in;
		n.mi_s2 = q.mi_s1;

		// Bus handshakes: one write and one read in flight
		n.axw     = awvalid && wvalid && !q.axw && !q.bvalid;
		n.arready = arvalid && !q.arready && !q.rvalid;
		if (q.bvalid && bready)
			n.bvalid = 1'b0;
		if (q.rvalid && rready)
			n.rvalid = 1'b0;
		if (rd) begin
			n.rvalid = 1'b1;
			n.rresp  = rmap ? BSP_RESP_OK : BSP_RESP_ERR;
			n.rdata  = {24'h000000, rmap ? rbyte : 8'h00};
		end

		// Shift engine
		if (busy) begin
			if (master) begin
				if (q.div == 10'(bsp_half({q.clock_divider_top_bit, q.ctrl[1:0]}) - 10'h001)) begin // [R10] [R21]
					n.div    = 10'h000;
					tick     = 1'b1;
					n.sclk_o = ~q.sclk_o;
				end else begin
					n.div = q.div + 10'h001;
				end
				din = q.mi_s2;
			end else begin
				tick = selected && (q.ck_s2 != q.ck_s3);
				din  = q.mo_s2;
			end
			lead   = !q.edg[0];
			sample = lead ^ clock_phase;                                  // [R8] [R9]
			if (tick) begin
				if (sample)                                        // [R19]
					n.sh = ord ? {din, q.sh[7:1]} : {q.sh[6:0], din}; // [R6]
				if (q.edg == BSP_EDGE_LAST) begin
					n.buff[q.idx] = n.sh;                          // [R21]
					n.edg         = 4'h0;
					if (q.idx == q.xcnt) begin                     // [R1]
						n.st    = BSP_ST_IDLE;
						ev_done = 1'b1;                            // [R12]
					end else begin
						n.idx = q.idx + 3'h1;                      // [R2]
						n.sh  = q.buff[q.idx + 3'h1];
					end
				end else begin
					n.edg = q.edg + 4'h1;
				end
				if (!sample) begin
					if (master)
						n.mosi_o = ord ? n.sh[0] : n.sh[7];
					else
						n.miso_o = ord ? n.sh[0] : n.sh[7];
				end
			end
		end
		if (!busy)
			n.sclk_o = clock_polarity;                                       // [R7]
		if (!master && !selected)
			n.miso_o = 1'b1;                                       // [R20]

		// Register writes
		if (wr) begin
			n.bvalid = 1'b1;
			n.bresp  = wmap ? BSP_RESP_OK : BSP_RESP_ERR;
		end
		if (wr && wmap && wstrb[0]) begin
			if (awaddr == BSP_ADDR_CTRL)
				n.ctrl = wdata[7:0];
			else if (awaddr == BSP_ADDR_STAT) begin
				if (!wdata[BSP_S_DONE])
					n.done = 1'b0;
				if (!wdata[BSP_S_WRITE_COLLISION_FLAG])
					n.write_collision_flag = 1'b0;                                 // [R15]
				n.clock_divider_top_bit = wdata[BSP_S_CLOCK_DIVIDER_TOP_BIT];
				n.xcnt = wdata[2:0];
			end else if (awaddr == BSP_ADDR_IE) begin
				n.pie = wdata[BSP_I_PIE];
				n.gie = wdata[BSP_I_GIE];
			end else if (busy && bidx <= q.xcnt) begin
				ev_write_collision_flag = 1'b1;                                    // [R14] [R18]
			end else begin
				n.buff[bidx] = wdata[7:0];
				if (!busy && en && bidx == q.xcnt) begin           // [R17]
					n.st  = BSP_ST_XFER;
					n.idx = 3'h0;
					n.edg = 4'h0;
					n.div = 10'h000;
					n.sh  = n.buff[0];                             // [R2]
					if (!clock_phase) begin                               // [R9]
						if (master)
							n.mosi_o = ord ? n.buff[0][0] : n.buff[0][7];
						else
							n.miso_o = ord ? n.buff[0][0] : n.buff[0][7];
					end
				end
			end
		end

		// Mode fault: another master pulled select low
		if (mfault) begin
			n.ctrl[BSP_C_MASTER_SELECT] = 1'b0;
			n.st               = BSP_ST_IDLE;
			ev_done            = 1'b1;                             // [R13]
		end
		if (!en)
			n.st = BSP_ST_IDLE;

		// Hardware sets win over software clears
		if (ev_done)
			n.done = 1'b1;
		if (ev_write_collision_flag)
			n.write_collision_flag = 1'b1;

		// Pin ownership; divider select ignored as slave
		n.sclk_oe = en && master;                                  // [R5]
		n.mosi_oe = en && master;
		n.miso_oe = en && !master;
		n.irq     = n.done && n.pie && n.gie;                      // [R12]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= BSP_STATE_RST;
		else
			q <= n;
	end

	assign awready              = q.axw;
	assign wready               = q.axw;
	assign bvalid               = q.bvalid;
	assign bresp                = q.bresp;
	assign arready              = q.arready;
	assign rvalid               = q.rvalid;
	assign rdata                = q.rdata;
	assign rresp                = q.rresp;
	assign serial_clock_pin_out = q.sclk_o;
	assign serial_clock_pin_oe  = q.sclk_oe;
	assign master_out_pin_out   = q.mosi_o;
	assign master_out_pin_oe    = q.mosi_oe;
	assign master_in_pin_out    = q.miso_o;
	assign master_in_pin_oe     = q.miso_oe;
	assign irq                  = q.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_fast_toggle;
		$changed(q.sclk_o) ##1 !$changed(q.sclk_o) ##1 $changed(q.sclk_o);
	endsequence
	sequence s_buf_write_in_use;
		wr && wmap && wstrb[0] && widx >= 4'h2 && widx <= 4'h9 && bidx <= q.xcnt;
	endsequence

	a_irq_gate: assert property (n.done && n.pie && n.gie |=> irq) // [R12]
		else $error("interrupt not raised for done flag");
	a_done_end: assert property ($fell(busy) && en |-> q.done) // [R12]
		else $error("transfer ended without done flag");
	a_write_collision_flag_set: assert property (s_buf_write_in_use and busy |=> q.write_collision_flag) // [R14]
		else $error("collision not flagged");
	a_write_collision_flag_hold: assert property (q.write_collision_flag && !(wr && awaddr == BSP_ADDR_STAT
		&& !wdata[BSP_S_WRITE_COLLISION_FLAG]) |=> q.write_collision_flag) // [R15]
		else $error("collision flag dropped without a zero write");
	a_start_xfer: assert property (s_buf_write_in_use and (!busy && en && bidx == q.xcnt
		&& !mfault) |=> busy) // [R17]
		else $error("transfer did not start");
	a_pins_free: assert property (!en |=> !q.sclk_oe && !q.mosi_oe && !q.miso_oe) // [R5]
		else $error("pins driven while disabled");
	a_sclk_idle: assert property (!busy ##1 !busy |-> q.sclk_o == $past(clock_polarity)) // [R7]
		else $error("idle clock level wrong");
	a_slave_high: assert property (en && !master && !selected |=> q.miso_o && q.miso_oe) // [R20]
		else $error("unselected slave not holding output high");
	a_mode_fault: assert property (mfault |=> q.done && !master_select) // [R13]
		else $error("select fault not handled");
	a_div_fast: assert property (busy && master && {q.clock_divider_top_bit, q.ctrl[1:0]} == 3'h0
		&& $changed(q.sclk_o) ##1 (busy && master) [*2] |-> ##0 1'b1 ##0
		$past(q.sclk_o, 2) != q.sclk_o) // [R10]
		else $error("fastest divider half period wrong");
endmodule : bsp_port
